// File: rtl/scg_map.svh
// timing and sizing constants for the sleep-aware clock gating controller
// assumes inclusion by rtl files only; definitions only
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_ENDPOINTS     8
`define SCG_SYNC_STAGES   2
`define SCG_WAIT_W        2
`define SCG_GATE_RESET    1'h0
`define SCG_HOLD_RESET    1'h0
`define SCG_CLK_PERIOD_NS 100
`endif

// File: rtl/scg_pkg.sv
// types for the sleep-aware clock gating controller
// assumes nothing of its surroundings
package scg_pkg;
	typedef enum logic [1:0] {
		SCG_AWAKE,
		SCG_SLEEP,
		SCG_WAKING
	} scg_state_e;
endpackage : scg_pkg

// File: rtl/scg_sleep_aware_clock_gating.sv
// sleep-aware top-level clock gating controller
// assumes all inputs come from logic on clk_sys; gate enables feed
// per-endpoint clock gating cells that sample on the low phase
// an enable that moves shifts its endpoint's clock by whole periods only
// Functional notes
// - every endpoint has its own gate, and either mask may change at any time.
// - gates open and close only on whole clock periods, never mid-cycle.
// - gating only stops an endpoint clock and never resets the endpoint.
// - two masks of identical layout exist, one awake and one sleep, one bit per endpoint.
// - while awake the gates follow exactly the awake mask.
// - while in sleep the gates follow the sleep mask instead.
// - sleep needs both processors to report that they are asleep.
// - sleep also needs the dma to have no outstanding transfer, at the same time.
// - sleep ends as soon as either processor takes an interrupt, returning to the awake mask.
// - on wake the processors are held off the bus until the awake gates are running.
// - processor subsystem clocks are not gated here.
// - any mask combination is accepted, even one enabled only in sleep.
// - an interrupt that wakes a processor switches the gates back to the awake mask.
`timescale 1ns/10ps
`include "scg_map.svh"
module scg_sleep_aware_clock_gating #(
	parameter int ENDPOINTS = `SCG_ENDPOINTS
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	// gate masks
	input  wire logic [ENDPOINTS-1:0] awakeGateMask,
	input  wire logic [ENDPOINTS-1:0] sleepGateMask,
	// processor and dma status
	input  wire logic                 proc0Asleep,
	input  wire logic                 proc1Asleep,
	input  wire logic                 proc0WakeIrq,
	input  wire logic                 proc1WakeIrq,
	input  wire logic                 dmaBusy,
	// gate enables, bus hold and sleep flag
	output logic      [ENDPOINTS-1:0] gateEnable,
	output logic                      busHold,
	output logic                      inSleep
);
	localparam int STAGES = `SCG_SYNC_STAGES;

	scg_pkg::scg_state_e        state;
	scg_pkg::scg_state_e        next_state;
	logic [`SCG_WAIT_W-1:0]     waitCount;
	logic [`SCG_WAIT_W-1:0]     next_waitCount;
	logic                       next_busHold;
	logic                       next_inSleep;
	logic [ENDPOINTS-1:0]       selMask;
	logic [ENDPOINTS-1:0]       gateMid;
	logic                       wakeIrq;
	logic                       sleepReady;

	assign wakeIrq    = proc0WakeIrq | proc1WakeIrq;
	assign sleepReady = proc0Asleep & proc1Asleep & ~dmaBusy;

	// one decode serves both the sleep flag and the mask select
	function automatic logic selectsSleepMask(input scg_pkg::scg_state_e st);
		return (st == scg_pkg::SCG_SLEEP);
	endfunction : selectsSleepMask

	always_comb begin
		next_state     = state;
		next_waitCount = waitCount;
		unique case (state)
			scg_pkg::SCG_AWAKE: begin
				// an interrupt already pending keeps us awake
				if (sleepReady && !wakeIrq) begin
					next_state = scg_pkg::SCG_SLEEP;
				end
			end
			scg_pkg::SCG_SLEEP: begin
				if (wakeIrq) begin
					next_state     = scg_pkg::SCG_WAKING;
					next_waitCount = `SCG_WAIT_W'(STAGES - 1);
				end
			end
			scg_pkg::SCG_WAKING: begin
				// wait for the awake mask to pass the gate pipeline
				if (waitCount == '0) begin
					next_state = scg_pkg::SCG_AWAKE;
				end else begin
					next_waitCount = waitCount - `SCG_WAIT_W'(1);
				end
			end
		endcase
		next_busHold = (next_state != scg_pkg::SCG_AWAKE);
		next_inSleep = selectsSleepMask(next_state);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state     <= scg_pkg::SCG_AWAKE;
			waitCount <= '0;
			busHold   <= `SCG_HOLD_RESET;
			inSleep   <= 1'h0;
		end else begin
			state     <= next_state;
			waitCount <= next_waitCount;
			busHold   <= next_busHold;
			inSleep   <= next_inSleep;
		end
	end

	// only the sleep state selects the sleep mask; waking already uses awake
	assign selMask = selectsSleepMask(state) ? sleepGateMask : awakeGateMask;

	// per-endpoint gates; processor subsystems have none here
	genvar i;
	generate
		for (i = 0; i < ENDPOINTS; i++) begin : g_gate
			logic next_mid;
			logic next_gate;
			always_comb begin
				next_mid  = selMask[i];
				next_gate = gateMid[i];
			end
			// enables change only on a clock edge, so the gating cell sees
			// a stable level for a whole period and cannot clip a pulse
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					gateMid[i]    <= `SCG_GATE_RESET;
					gateEnable[i] <= `SCG_GATE_RESET;
				end else begin
					gateMid[i]    <= next_mid;
					gateEnable[i] <= next_gate;
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_sleep_entry_taken: assert property (
		state == scg_pkg::SCG_AWAKE && proc0Asleep && proc1Asleep && !dmaBusy && !wakeIrq
		|=> state == scg_pkg::SCG_SLEEP && inSleep)
		else $error("sleep not entered when all conditions held");
	a_no_sleep_dma_busy: assert property (
		state == scg_pkg::SCG_AWAKE && dmaBusy |=> state == scg_pkg::SCG_AWAKE)
		else $error("sleep entered with dma busy");
	a_no_sleep_one_proc: assert property (
		state == scg_pkg::SCG_AWAKE && !(proc0Asleep && proc1Asleep) |=> !inSleep)
		else $error("sleep entered with a processor awake");
	a_wake_on_irq: assert property (
		state == scg_pkg::SCG_SLEEP && wakeIrq |=> state == scg_pkg::SCG_WAKING ##2 state == scg_pkg::SCG_AWAKE)
		else $error("sleep exit not timely");
	a_gate_follows_mask: assert property (
		$past(reset_n) && $past(reset_n, 2) |-> gateEnable == $past(selMask, 2))
		else $error("gate enables do not follow selected mask");
	a_sleep_mask_used: assert property (
		state == scg_pkg::SCG_SLEEP ##1 state == scg_pkg::SCG_SLEEP ##1 state == scg_pkg::SCG_SLEEP
		|-> gateEnable == $past(sleepGateMask, 2))
		else $error("sleep mask not applied");
	a_hold_through_wake: assert property (
		$rose(state == scg_pkg::SCG_WAKING) |-> busHold [*2] ##1 !busHold)
		else $error("bus hold wrong around wake");
	a_hold_release_gates: assert property (
		$fell(busHold) |-> gateEnable == $past(awakeGateMask, 2))
		else $error("bus released before awake gates applied");

	// entry conditions
	a_entry_both_asleep: assert property (
		$rose(inSleep) |-> $past(proc0Asleep) && $past(proc1Asleep))
		else $error("sleep entered without both processors asleep");
	a_entry_dma_idle: assert property (
		$rose(inSleep) |-> !$past(dmaBusy))
		else $error("sleep entered with a dma transfer outstanding");
	a_irq_blocks_entry: assert property (
		state == scg_pkg::SCG_AWAKE && wakeIrq |=> !inSleep)
		else $error("sleep entered with a wake interrupt pending");
	a_hold_rises_sleep: assert property (
		$rose(busHold) |-> inSleep)
		else $error("bus hold raised outside sleep entry");

	// wake path and bus hold
	a_sleep_stays: assert property (
		inSleep && !wakeIrq |=> inSleep)
		else $error("sleep left without an interrupt");
	a_either_proc_wakes: assert property (
		inSleep && (proc0WakeIrq != proc1WakeIrq) |=> !inSleep)
		else $error("single processor interrupt did not end sleep");
	a_sleep_holds_bus: assert property (
		inSleep |-> busHold)
		else $error("bus released while asleep");
	a_awake_no_hold: assert property (
		state == scg_pkg::SCG_AWAKE |-> !busHold)
		else $error("bus held while awake");
	a_waking_no_sleep: assert property (
		state == scg_pkg::SCG_WAKING |=> state != scg_pkg::SCG_SLEEP)
		else $error("sleep re-entered before the wake finished");
	a_wake_bounded: assert property (
		state == scg_pkg::SCG_WAKING |-> ##[1:2] state == scg_pkg::SCG_AWAKE)
		else $error("wake took too long");
	a_irq_restores_mask: assert property (
		inSleep && wakeIrq |-> ##3 gateEnable == $past(awakeGateMask, 2))
		else $error("awake mask not restored after wake");

	// gate pipeline
	a_gate_pipe_stage: assert property (
		$past(reset_n) |-> gateEnable == $past(gateMid))
		else $error("gate enable skipped its register stage");
	a_gate_hold_stable: assert property (
		$past(reset_n) && $stable(gateMid) |=> $stable(gateEnable))
		else $error("gate enable moved without a mask change");
	a_sleep_mask_reaches: assert property (
		$rose(inSleep) |-> ##2 gateEnable == $past(sleepGateMask, 2))
		else $error("sleep mask late after entry");
	a_sleep_only_gate: assert property (
		inSleep && $past(inSleep) && $past(inSleep, 2)
		|-> (gateEnable & ~awakeGateMask) == ($past(sleepGateMask, 2) & ~awakeGateMask))
		else $error("sleep-only endpoint not enabled in sleep");

	c_sleep_entry: cover property (state == scg_pkg::SCG_AWAKE ##1 state == scg_pkg::SCG_SLEEP);
	c_full_wake:   cover property (state == scg_pkg::SCG_SLEEP ##1 state == scg_pkg::SCG_WAKING ##2 !busHold);
	c_sleep_only:  cover property (inSleep && (sleepGateMask & ~awakeGateMask) != '0);
	c_irq_block:   cover property (state == scg_pkg::SCG_AWAKE && sleepReady && wakeIrq);
	c_proc1_wake:  cover property (state == scg_pkg::SCG_SLEEP && proc1WakeIrq && !proc0WakeIrq);
endmodule : scg_sleep_aware_clock_gating

// File: testbench/scg_proc_model.sv
// behavioural processors and dma seen by the clock gating controller
// assumes bench requests change just after clk_sys rising edges
`timescale 1ns/10ps
module scg_proc_model (
	// requests from the bench
	input  wire logic [1:0] wantSleep,
	input  wire logic [1:0] wakeIrq,
	input  wire logic       dmaOn,
	// towards the controller
	output logic            proc0Asleep,
	output logic            proc1Asleep,
	output logic            proc0WakeIrq,
	output logic            proc1WakeIrq,
	output logic            dmaBusy
);
	// a woken core drops its asleep flag only when the bench clears wantSleep,
	// so an interrupt and both asleep flags may overlap for a cycle or more
	assign proc0Asleep  = wantSleep[0];
	assign proc1Asleep  = wantSleep[1];
	assign proc0WakeIrq = wakeIrq[0];
	assign proc1WakeIrq = wakeIrq[1];
	assign dmaBusy      = dmaOn;
endmodule : scg_proc_model

// File: testbench/test_sleep_aware_clock_gating.sv
// self-checking bench for the sleep-aware clock gating controller
// assumes the default of eight endpoints
`timescale 1ns/10ps
module test_sleep_aware_clock_gating;
	logic       clk_sys = 1'h0, reset_n = 1'h0, dmaOn = 1'h0;
	// awake mask keeps the fabric and stack memory endpoints, bits 2 to 5, running
	logic [7:0] awakeGateMask = 8'h3C, sleepGateMask = 8'hC3, gateEnable;
	logic [1:0] wantSleep = 2'h0, irq = 2'h0;
	logic       p0, p1, w0, w1, dma, busHold, inSleep;
	int         nMismatch = 0, nTests = 0;
	always #50 clk_sys = ~clk_sys;
	scg_proc_model PM (.wantSleep(wantSleep), .wakeIrq(irq), .dmaOn(dmaOn), .proc0Asleep(p0),
		.proc1Asleep(p1), .proc0WakeIrq(w0), .proc1WakeIrq(w1), .dmaBusy(dma));
	scg_sleep_aware_clock_gating DUT (.clk_sys(clk_sys), .reset_n(reset_n), .awakeGateMask(awakeGateMask),
		.sleepGateMask(sleepGateMask), .proc0Asleep(p0), .proc1Asleep(p1), .proc0WakeIrq(w0),
		.proc1WakeIrq(w1), .dmaBusy(dma), .gateEnable(gateEnable), .busHold(busHold), .inSleep(inSleep));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	// one processor awake, then dma busy: both must block entry
	task automatic t_refuse();
		@(posedge clk_sys) wantSleep <= 2'h1;
		step(4);
		check({7'h00, inSleep}, 8'h00);
		@(posedge clk_sys) wantSleep <= 2'h3;
		dmaOn <= 1'h1;
		step(4);
		check({6'h00, busHold, inSleep}, 8'h00);
		check(gateEnable, awakeGateMask);
		// both asleep but an interrupt already pending: entry is refused
		@(posedge clk_sys) dmaOn <= 1'h0;
		irq <= 2'h2;
		step(3);
		check({6'h00, busHold, inSleep}, 8'h00);
		@(posedge clk_sys) irq <= 2'h0;
		wantSleep <= 2'h0;
	endtask : t_refuse
	// sleep mask holds bits absent from the awake mask
	task automatic t_sleep();
		step(1);
		check({6'h00, busHold, inSleep}, 8'h03);
		step(1);
		check(gateEnable, awakeGateMask);
		step(1);
		check(gateEnable, sleepGateMask);
	endtask : t_sleep
	task automatic t_maskChange();
		@(posedge clk_sys) sleepGateMask <= 8'h81;
		step(1);
		check(gateEnable, 8'hC3);
		step(2);
		check(gateEnable, 8'h81);
		@(posedge clk_sys) sleepGateMask <= 8'hC3;
		step(3);
	endtask : t_maskChange
	task automatic t_wake(input logic [1:0] which);
		@(posedge clk_sys) irq <= which;
		step(1);
		check({6'h00, busHold, inSleep}, 8'h02);
		@(posedge clk_sys) irq <= 2'h0;
		wantSleep <= 2'h0;
		#1;
		check({7'h00, busHold}, 8'h01);
		step(1);
		check({7'h00, busHold}, 8'h00);
		check(gateEnable, awakeGateMask);
	endtask : t_wake
	initial begin
		#(100 * 2000);
		nMismatch++;
		wrap_up();
	end
	initial begin
		step(3);
		check(gateEnable, 8'h00);
		check({6'h00, busHold, inSleep}, 8'h00);
		repeat (7) @(posedge clk_sys);
		reset_n <= 1'h1;
		step(3);
		check(gateEnable, awakeGateMask);
		t_refuse();
		// back-to-back: sleep again right after the first wake
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys) wantSleep <= 2'h3;
			t_sleep();
			if (i == 0) t_maskChange();
			t_wake(2'h1 << i);
		end
		wrap_up();
	end
endmodule : test_sleep_aware_clock_gating
